/* File: design/oms_mode_select.sv */
// Oscillator mode select: system clock tick source, pin roles and trim.
// Assumes an APB master on core_clk and a config strap stable at reset.
`timescale 1ns/100ps
`default_nettype none
module oms_mode_select #(
    parameter int unsigned ADDR_W   = 8,
    parameter int unsigned SLEW_CYC = oms_pkg::TRIM_SLEW_CYC
) (
    // Clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // Configuration strap
    input  wire logic [3:0]        osc_mode_config_field,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Clock input pin
    input  wire logic              clock_in_pin_i,
    output logic                   clock_in_pin_o,
    output logic                   clock_in_pin_oe,
    // Clock output pin
    input  wire logic              clock_out_pin_i,
    output logic                   clock_out_pin_o,
    output logic                   clock_out_pin_oe,
    // Oscillator state
    output logic                   sys_clk_tick,
    output logic                   fast_osc_en,
    output logic                   slow_osc_en
);
    if (ADDR_W < 5 || SLEW_CYC < 1) begin : g_bad_param
        $error("oms_mode_select: bad parameter");
    end

    localparam int unsigned SC_W = $clog2(SLEW_CYC + 1);
    localparam logic [SC_W-1:0] SLEW_LAST = SC_W'(SLEW_CYC - 1);

    // Synchronised pins: [1] is clock_out pin, [0] is clock_in pin
    logic [1:0] pin_s;
    logic       clk_in_prev_q;
    logic       clk_in_rise;
    oms_sync #(.W(2)) u_pin_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .async_in ({clock_out_pin_i, clock_in_pin_i}),
        .sync_out (pin_s)
    );

    // Registers
    oms_pkg::oms_mode_t mode_q, mode_d;
    logic                        cfg_done_q, cfg_done_d;
    logic [oms_pkg::TRIM_W-1:0]  trim_q, trim_d;
    logic [oms_pkg::TRIM_W-1:0]  cur_q, cur_d;
    logic [SC_W-1:0]             slew_q, slew_d;
    logic [oms_pkg::IFS_W-1:0]   ifs_q, ifs_d;
    logic [oms_pkg::FEAT_W-1:0]  feat_q, feat_d;
    logic [1:0]                  gout_q, gout_d;
    logic [1:0]                  goe_q, goe_d;
    logic [31:0]                 rd_q, rd_d;
    logic [oms_pkg::PS_W-1:0]    ps_q, ps_d;
    logic                        div_q, div_d;
    logic                        fosc4_q, fosc4_d;
    logic                        tick_q, tick_d;
    logic                        fen_q, fen_d;
    logic                        sen_q, sen_d;
    logic [1:0]                  po_q, po_d;
    logic [1:0]                  poe_q, poe_d;
    logic                        prev_d;

    logic [7:0] addr;
    logic       wr_en;
    logic       setup;
    logic       mapped;
    logic       fast_tick;
    logic       slow_tick;
    logic       internal_mode;
    logic       ext_pin_mode;
    logic [oms_pkg::PS_W-1:0] ps_mask;
    logic [oms_pkg::NCO_W-1:0] fast_incr;
    logic [oms_pkg::NCO_W-1:0] slow_incr;

    // RULE14: uneven trim steps
    // Uneven, non-monotonic step size per trim code
    function automatic logic [31:0] trim_incr(input logic [31:0] base, input logic [5:0] code);
        logic signed [39:0] step;
        logic signed [39:0] d;
        step = $signed({8'h00, base >> oms_pkg::TRIM_SHIFT});
        d    = $signed({{34{code[5]}}, code}) * step;
        if (code[0]) begin
            d = d - step - (step >>> 1);
        end
        return 32'($signed({8'h00, base}) + d);
    endfunction

    always_comb begin
        addr          = 8'(paddr);
        setup         = psel && !penable;
        wr_en         = clk_en && psel && penable && pwrite;
        mapped        = addr == oms_pkg::OFS_TRIM || addr == oms_pkg::OFS_CTRL ||
                        addr == oms_pkg::OFS_FEAT || addr == oms_pkg::OFS_GPIO ||
                        addr == oms_pkg::OFS_STAT;
        pready        = 1'b1;
        pslverr       = psel && penable && !mapped;
        internal_mode = mode_q == oms_pkg::internal_osc_div_out_mode ||
                        mode_q == oms_pkg::internal_osc_dual_gpio_mode;
        ext_pin_mode  = !internal_mode;
        ps_mask       = oms_pkg::PS_W'((7'h01 << (3'h7 - ifs_q)) - 7'h01);
        clk_in_rise   = pin_s[0] && !clk_in_prev_q;
        // RULE12: slow rate shifted
        // RULE13: current trim drives both
        fast_incr     = trim_incr(oms_pkg::FAST_INC, cur_q);
        slow_incr     = trim_incr(oms_pkg::SLOW_INC, cur_q);
    end

    // RULE6: fast 8 MHz source
    oms_nco #(.W(oms_pkg::NCO_W)) u_fast (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .run      (fen_q),
        .incr     (fast_incr),
        .tick     (fast_tick)
    );

    // RULE12: slow source off nominal
    oms_nco #(.W(oms_pkg::NCO_W)) u_slow (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .run      (sen_q),
        .incr     (slow_incr),
        .tick     (slow_tick)
    );

    // Configuration, registers and trim slew
    always_comb begin
        mode_d     = mode_q;
        cfg_done_d = cfg_done_q;
        trim_d     = trim_q;
        cur_d      = cur_q;
        slew_d     = slew_q;
        ifs_d      = ifs_q;
        feat_d     = feat_q;
        gout_d     = gout_q;
        goe_d      = goe_q;
        rd_d       = rd_q;
        // RULE17: strap caught after release
        // RULE19: pin roles fixed at reset
        if (clk_en && !cfg_done_q) begin
            cfg_done_d = 1'b1;
            case (osc_mode_config_field)
                4'h0: mode_d = oms_pkg::low_power_xtal_mode;
                4'h1: mode_d = oms_pkg::std_xtal_mode;
                4'h2: mode_d = oms_pkg::high_speed_xtal_mode;
                4'h3: mode_d = oms_pkg::resistor_capacitor_with_div_out_mode;
                4'h4: mode_d = oms_pkg::ext_clock_with_div_out_mode;
                4'h5: mode_d = oms_pkg::ext_clock_pin_gpio_mode;
                4'h6: mode_d = oms_pkg::high_speed_pll_mode;
                4'h7: mode_d = oms_pkg::resistor_capacitor_pin_gpio_mode;
                4'h8: mode_d = oms_pkg::internal_osc_dual_gpio_mode;
                4'h9: mode_d = oms_pkg::internal_osc_div_out_mode;
                default: mode_d = oms_pkg::ext_clock_with_div_out_mode;
            endcase
        end
        if (wr_en) begin
            case (addr)
                // RULE15: signed trim code stored
                oms_pkg::OFS_TRIM: trim_d = pwdata[oms_pkg::TRIM_W-1:0];
                oms_pkg::OFS_CTRL: ifs_d  = pwdata[oms_pkg::IFS_LSB +: oms_pkg::IFS_W];
                oms_pkg::OFS_FEAT: feat_d = pwdata[oms_pkg::FEAT_W-1:0];
                oms_pkg::OFS_GPIO: begin
                    gout_d = pwdata[oms_pkg::OUT_BIT +: 2];
                    goe_d  = pwdata[oms_pkg::OE_LSB +: 2];
                end
                default: ;
            endcase
        end
        // RULE13: gradual shift toward setting
        if (clk_en) begin
            if (cur_q == trim_q) begin
                slew_d = '0;
            end else if (slew_q == SLEW_LAST) begin
                slew_d = '0;
                if ($signed(cur_q) < $signed(trim_q)) begin
                    cur_d = cur_q + 6'h01;
                end else begin
                    cur_d = cur_q - 6'h01;
                end
            end else begin
                slew_d = slew_q + SC_W'(1);
            end
        end
        if (clk_en && setup) begin
            rd_d = 32'h0;
            case (addr)
                // RULE16: upper trim bits read zero
                oms_pkg::OFS_TRIM: rd_d[oms_pkg::TRIM_W-1:0] = trim_q;
                oms_pkg::OFS_CTRL: rd_d[oms_pkg::IFS_LSB +: oms_pkg::IFS_W] = ifs_q;
                oms_pkg::OFS_FEAT: rd_d[oms_pkg::FEAT_W-1:0] = feat_q;
                oms_pkg::OFS_GPIO: begin
                    rd_d[oms_pkg::OUT_BIT +: 2] = gout_q;
                    rd_d[oms_pkg::OE_LSB +: 2]  = goe_q;
                    rd_d[oms_pkg::RDP_LSB]      = pin_s[1];
                    rd_d[oms_pkg::RDP_LSB + 1]  = pin_s[0];
                end
                oms_pkg::OFS_STAT: begin
                    rd_d[3:0]              = mode_q;
                    rd_d[oms_pkg::ST_FAST] = fen_q;
                    rd_d[oms_pkg::ST_SLOW] = sen_q;
                end
                default: ;
            endcase
        end
    end

    // Clock source, dividers and pins
    always_comb begin
        ps_d    = ps_q;
        div_d   = div_q;
        fosc4_d = fosc4_q;
        tick_d  = 1'b0;
        fen_d   = fen_q;
        sen_d   = sen_q;
        po_d    = po_q;
        poe_d   = poe_q;
        prev_d  = clk_in_prev_q;
        if (clk_en) begin
            prev_d = pin_s[0];
            // RULE7: fast enable by selection
            fen_d  = ifs_q != oms_pkg::IFS_SLOW;
            // RULE8: slow enable conditions
            sen_d  = (cfg_done_q && internal_mode) || (feat_q != '0);
            if (fast_tick) begin
                ps_d = ps_q + oms_pkg::PS_W'(1);
            end
            if (!cfg_done_q) begin
                tick_d = 1'b0;
            end else if (ext_pin_mode) begin
                // RULE1: no start-up wait
                tick_d = clk_in_rise;
            end else begin
                // RULE9: tap selection
                // RULE18: select decode
                case (ifs_q)
                    oms_pkg::IFS_SLOW: tick_d = slow_tick;
                    oms_pkg::IFS_FAST: tick_d = fast_tick;
                    default:           tick_d = fast_tick && ((ps_q & ps_mask) == ps_mask);
                endcase
            end
            if (tick_q) begin
                div_d = !div_q;
                if (div_q == 1'(oms_pkg::FOSC_HALF - 1)) begin
                    fosc4_d = !fosc4_q;
                end
            end
            po_d  = '0;
            poe_d = '0;
            if (cfg_done_q) begin
                case (mode_q)
                    // RULE2: external clock/4 out
                    // RULE4: RC clock/4 out
                    oms_pkg::ext_clock_with_div_out_mode,
                    oms_pkg::resistor_capacitor_with_div_out_mode: begin
                        po_d[1]  = fosc4_q;
                        poe_d[1] = 1'b1;
                    end
                    // RULE3: external gpio on bit 6
                    // RULE5: RC gpio on bit 6
                    oms_pkg::ext_clock_pin_gpio_mode,
                    oms_pkg::resistor_capacitor_pin_gpio_mode: begin
                        po_d[1]  = gout_q[0];
                        poe_d[1] = goe_q[0];
                    end
                    // RULE10: clock/4 out, bit 7 gpio
                    oms_pkg::internal_osc_div_out_mode: begin
                        po_d  = {fosc4_q, gout_q[1]};
                        poe_d = {1'b1, goe_q[1]};
                    end
                    // RULE11: both pins gpio
                    oms_pkg::internal_osc_dual_gpio_mode: begin
                        po_d  = {gout_q[0], gout_q[1]};
                        poe_d = {goe_q[0], goe_q[1]};
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q        <= oms_pkg::ext_clock_with_div_out_mode;
            cfg_done_q    <= 1'b0;
            trim_q        <= '0;
            cur_q         <= '0;
            slew_q        <= '0;
            ifs_q         <= oms_pkg::IFS_RST;
            feat_q        <= '0;
            gout_q        <= '0;
            goe_q         <= '0;
            rd_q          <= '0;
            ps_q          <= '0;
            div_q         <= 1'b0;
            fosc4_q       <= 1'b0;
            tick_q        <= 1'b0;
            fen_q         <= 1'b0;
            sen_q         <= 1'b0;
            po_q          <= '0;
            poe_q         <= '0;
            clk_in_prev_q <= 1'b0;
        end else begin
            mode_q        <= mode_d;
            cfg_done_q    <= cfg_done_d;
            trim_q        <= trim_d;
            cur_q         <= cur_d;
            slew_q        <= slew_d;
            ifs_q         <= ifs_d;
            feat_q        <= feat_d;
            gout_q        <= gout_d;
            goe_q         <= goe_d;
            rd_q          <= rd_d;
            ps_q          <= ps_d;
            div_q         <= div_d;
            fosc4_q       <= fosc4_d;
            tick_q        <= tick_d;
            fen_q         <= fen_d;
            sen_q         <= sen_d;
            po_q          <= po_d;
            poe_q         <= poe_d;
            clk_in_prev_q <= prev_d;
        end
    end

    always_comb begin
        prdata           = rd_q;
        sys_clk_tick     = tick_q;
        fast_osc_en      = fen_q;
        slow_osc_en      = sen_q;
        clock_out_pin_o  = po_q[1];
        clock_out_pin_oe = poe_q[1];
        clock_in_pin_o   = po_q[0];
        clock_in_pin_oe  = poe_q[0];
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    trim_read_zero_a: assert property ( // RULE16
        clk_en && setup && addr == oms_pkg::OFS_TRIM |=> prdata[7:6] == 2'b00 && prdata[5:0] == $past(trim_q))
        else $error("trim read shows upper bits or wrong value");
    ext_no_wait_a: assert property ( // RULE1
        clk_en && cfg_done_q && ext_pin_mode && clk_in_rise |=> sys_clk_tick)
        else $error("external edge gave no system tick");
    ext_div_out_a: assert property ( // RULE2
        clk_en && cfg_done_q && mode_q == oms_pkg::ext_clock_with_div_out_mode
        |=> clock_out_pin_oe && clock_out_pin_o == $past(fosc4_q))
        else $error("external mode not driving clock/4");
    ext_gpio_pin_a: assert property ( // RULE3
        clk_en && cfg_done_q && mode_q == oms_pkg::ext_clock_pin_gpio_mode
        |=> clock_out_pin_oe == $past(goe_q[0]) && !clock_in_pin_oe)
        else $error("external gpio mode pin wrong");
    rc_div_out_a: assert property ( // RULE4
        clk_en && cfg_done_q && mode_q == oms_pkg::resistor_capacitor_with_div_out_mode
        |=> clock_out_pin_oe)
        else $error("rc mode not driving output pin");
    dual_gpio_pins_a: assert property ( // RULE11
        clk_en && cfg_done_q && mode_q == oms_pkg::internal_osc_dual_gpio_mode
        |=> clock_in_pin_oe == $past(goe_q[1]) && clock_out_pin_oe == $past(goe_q[0]))
        else $error("dual gpio pins wrong");
    fast_enable_a: assert property ( // RULE7
        clk_en && ifs_q != oms_pkg::IFS_SLOW |=> fast_osc_en)
        else $error("fast source not enabled");
    slow_enable_a: assert property ( // RULE8
        clk_en && feat_q != '0 |=> slow_osc_en)
        else $error("slow source not enabled");
    trim_step_a: assert property ( // RULE13
        cur_q != $past(cur_q) |-> cur_q == $past(cur_q) + 6'h01 || cur_q == $past(cur_q) - 6'h01)
        else $error("trim jumped more than one code");
    mode_hold_a: assert property ( // RULE19
        cfg_done_q |=> $stable(mode_q) && cfg_done_q)
        else $error("mode changed after reset");

    trim_write_c: cover property (wr_en && addr == oms_pkg::OFS_TRIM ##[1:1000] cur_q == trim_q);
    fosc4_c: cover property (clock_out_pin_oe && $rose(clock_out_pin_o));
    internal_tick_c: cover property (internal_mode && sys_clk_tick);
endmodule
`default_nettype wire

/* File: design/oms_nco.sv */
// Phase accumulator that models one on-chip oscillator as a tick stream.
// Assumes incr is a fraction of the core clock scaled by 2**W.
`timescale 1ns/100ps
`default_nettype none
module oms_nco #(
    parameter int unsigned W = 32
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    // Control
    input  wire logic         run,
    input  wire logic [W-1:0] incr,
    // Output
    output logic              tick
);
    logic [W-1:0] acc_q;
    logic [W-1:0] acc_d;
    logic         tick_d;

    always_comb begin
        acc_d  = acc_q;
        tick_d = 1'b0;
        if (clk_en && run) begin
            {tick_d, acc_d} = {1'b0, acc_q} + {1'b0, incr};
        end else if (clk_en) begin
            acc_d = '0;
        end else begin
            tick_d = tick;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= '0;
            tick  <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick  <= tick_d;
        end
    end
endmodule
`default_nettype wire

/* File: design/oms_pkg.sv */
// Constants, register map and mode codes for the oscillator mode select block.
// Assumes a 50 MHz core clock and a 32-bit APB register port.
// Functional notes
// RULE1: External clock modes run with no start-up wait
// RULE2: External divided mode drives clock/4 on output pin
// RULE3: External gpio mode frees output pin as bit 6
// RULE4: RC divided mode drives clock/4 on output pin
// RULE5: RC gpio mode frees output pin as bit 6
// RULE6: Fast source 8 MHz, postscaler 125 kHz-4 MHz
// RULE7: Fast source enabled for selections 125 kHz-8 MHz
// RULE8: Slow source on for internal mode or features
// RULE9: Select output from fast, slow or postscaler taps
// RULE10: Internal divided mode: clock/4 out, input pin gpio
// RULE11: Internal dual gpio mode: both pins are gpio
// RULE12: Calibrated fast source shifts slow source rate
// RULE13: Trim slews gradually, no completion flag
// RULE14: Trim steps uneven and not monotonic
// RULE15: Trim field is signed six bit code
// RULE16: Trim upper bits read zero, reset zero
// RULE17: Mode taken from four-bit config at reset
// RULE18: Frequency select decode, default 110 is 4 MHz
// RULE19: Pin roles change only from reset-latched mode
package oms_pkg;
    localparam int unsigned CORE_HZ     = 50_000_000;
    localparam int unsigned CLK_NS      = 20;
    localparam int unsigned FAST_HZ     = 8_000_000;
    localparam int unsigned SLOW_NOM_HZ = 31_250;
    localparam int unsigned SLOW_HZ     = 31_000;
    localparam int unsigned NCO_W       = 32;
    localparam logic [NCO_W-1:0] FAST_INC = NCO_W'((64'(FAST_HZ) << NCO_W) / 64'(CORE_HZ));
    localparam logic [NCO_W-1:0] SLOW_INC = NCO_W'((64'(SLOW_HZ) << NCO_W) / 64'(CORE_HZ));
    localparam int unsigned TRIM_SHIFT    = 7;
    localparam int unsigned TRIM_SLEW_NS  = 20_000;
    localparam int unsigned TRIM_SLEW_CYC = (TRIM_SLEW_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FOSC_HALF     = 2;

    localparam logic [7:0] OFS_TRIM = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_FEAT = 8'h08;
    localparam logic [7:0] OFS_GPIO = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;

    localparam int unsigned TRIM_W   = 6;
    localparam int unsigned IFS_LSB  = 4;
    localparam int unsigned IFS_W    = 3;
    localparam logic [2:0]  IFS_RST  = 3'h6;
    localparam logic [2:0]  IFS_SLOW = 3'h0;
    localparam logic [2:0]  IFS_FAST = 3'h7;
    localparam int unsigned PS_W     = 6;
    localparam int unsigned FEAT_W   = 4;
    localparam int unsigned OUT_BIT  = 6;
    localparam int unsigned IN_BIT   = 7;
    localparam int unsigned OE_LSB   = 14;
    localparam int unsigned RDP_LSB  = 22;
    localparam int unsigned ST_FAST  = 4;
    localparam int unsigned ST_SLOW  = 5;

    typedef enum logic [3:0] {
        low_power_xtal_mode                   = 4'h0,
        std_xtal_mode                         = 4'h1,
        high_speed_xtal_mode                  = 4'h2,
        resistor_capacitor_with_div_out_mode  = 4'h3,
        ext_clock_with_div_out_mode           = 4'h4,
        ext_clock_pin_gpio_mode               = 4'h5,
        high_speed_pll_mode                   = 4'h6,
        resistor_capacitor_pin_gpio_mode      = 4'h7,
        internal_osc_dual_gpio_mode           = 4'h8,
        internal_osc_div_out_mode             = 4'h9
    } oms_mode_t;
endpackage

/* File: design/oms_sync.sv */
// Two-flop synchroniser for pin inputs.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module oms_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = clk_en ? async_in : meta_q;
        sync_d = clk_en ? meta_q : sync_out;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= meta_d;
            sync_out <= sync_d;
        end
    end
endmodule
`default_nettype wire

/* File: sim/oms_ext_clk.sv */
// External clock source model on the clock input pin.
// Assumes a half period counted in core clock cycles.
`timescale 1ns/100ps
`default_nettype none
module oms_ext_clk #(
    parameter int unsigned HALF = 5
) (
    // Clock
    input  wire logic core_clk,
    // Pin drive
    output var logic  ext_clk
);
    int unsigned cnt_q;
    initial begin
        ext_clk = 1'b0;
        cnt_q = 0;
    end
    // Free-running source, no start-up gap
    always @(posedge core_clk) begin
        if (cnt_q == HALF - 1) begin
            cnt_q <= 0;
            ext_clk <= ~ext_clk;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/oms_mode_select_tb_top.sv */
// Self-checking bench for the oscillator mode select block.
// Assumes the external clock model feeds the clock input pin.
`timescale 1ns/100ps
`default_nettype none
module oms_mode_select_tb_top;
    logic        core_clk, reset_n, psel, penable, pwrite, ext_clk, se;
    logic [3:0]  cfg;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, ci_o, ci_oe, co_o, co_oe, tick, fast_en, slow_en;
    logic [3:0]  md [6] = '{4'h4, 4'h5, 4'h3, 4'h7, 4'h9, 4'h8};
    logic [5:0]  od = 6'h15;
    int          err_count, num_checks, c;
    oms_mode_select #(.SLEW_CYC(4)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
        .osc_mode_config_field(cfg), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_in_pin_i(ci_oe ? ci_o : ext_clk), .clock_in_pin_o(ci_o), .clock_in_pin_oe(ci_oe),
        .clock_out_pin_i(co_oe & co_o), .clock_out_pin_o(co_o), .clock_out_pin_oe(co_oe),
        .sys_clk_tick(tick), .fast_osc_en(fast_en), .slow_osc_en(slow_en));
    oms_ext_clk #(.HALF(5)) u_src (.core_clk(core_clk), .ext_clk(ext_clk));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rng(input string n, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            test_done();
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rst(input logic [3:0] m);
        reset_n <= 1'b0;
        cfg <= m;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic cnt(input int cyc);
        c = 0;
        repeat (cyc) begin
            @(negedge core_clk);
            if (tick === 1'b1) c++;
        end
        @(posedge core_clk);
    endtask
    // Ticks between two rising edges of the divided output
    task automatic divc();
        int t, k, n;
        logic p;
        t = 0;
        k = 0;
        n = 0;
        p = co_o;
        while (k < 2 && t < 400) begin
            @(negedge core_clk);
            t++;
            if (co_o === 1'b1 && p === 1'b0) k++;
            else if (k == 1 && tick === 1'b1) n++;
            p = co_o;
        end
        if (t >= 400) begin
            err_count++;
            test_done();
        end
        chk("div out ticks", 32'h4, n);
        @(posedge core_clk);
    endtask
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cfg = 4'h4;
        err_count = 0;
        num_checks = 0;
        rst(4'h4);
        apb(1'b0, oms_pkg::OFS_TRIM, 32'h0);
        chk("trim reset", 32'h0, rd);
        apb(1'b1, oms_pkg::OFS_TRIM, 32'hffffffff);
        apb(1'b0, oms_pkg::OFS_TRIM, 32'h0);
        chk("trim field", 32'h3f, rd);
        apb(1'b0, oms_pkg::OFS_CTRL, 32'h0);
        chk("select reset", 32'h60, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, se);
        chk("unmapped read", 32'h0, rd);
        chk("ready", 32'h1, pready);
        chk("slow idle", 32'h0, slow_en);
        apb(1'b1, oms_pkg::OFS_FEAT, 32'h4);
        repeat (3) @(posedge core_clk);
        chk("slow by wdt", 32'h1, slow_en);
        for (int i = 0; i < 6; i++) begin
            rst(md[i]);
            apb(1'b0, oms_pkg::OFS_STAT, 32'h0);
            chk("mode code", md[i], rd[3:0]);
            chk("out pin oe", od[i], co_oe);
            if (od[i]) divc();
            apb(1'b1, oms_pkg::OFS_GPIO, 32'hc0c0);
            repeat (3) @(posedge core_clk);
            chk("in pin oe", md[i][3], ci_oe);
            if (!od[i]) chk("out pin gpio", 32'h1, co_o);
            chk("in pin out", md[i][3], ci_o);
        end
        for (int s = 7; s > 0; s--) begin
            apb(1'b1, oms_pkg::OFS_CTRL, 32'(s) << 4);
            cnt(2000);
            rng("tick count", (320 >> (7 - s)) - 1, (320 >> (7 - s)) + 1, c);
            chk("fast on", 32'h1, fast_en);
        end
        apb(1'b1, oms_pkg::OFS_CTRL, 32'h70);
        apb(1'b1, oms_pkg::OFS_TRIM, 32'h1f);
        cnt(2000);
        rng("trim max ticks", 330, 500, c);
        apb(1'b1, oms_pkg::OFS_TRIM, 32'h20);
        cnt(2000);
        rng("trim min ticks", 100, 310, c);
        apb(1'b1, oms_pkg::OFS_TRIM, 32'h0);
        apb(1'b1, oms_pkg::OFS_CTRL, 32'h0);
        cnt(3300);
        rng("slow ticks", 1, 3, c);
        chk("fast off", 32'h0, fast_en);
        chk("slow on", 32'h1, slow_en);
        test_done();
    end
endmodule
`default_nettype wire
